// File: logic/iolr_pkg.sv
// Purpose: Shared constants for the inverting octal latch/register
// Assumes: One system clock at 125 MHz
// Notes:   Variant codes select latch or register behaviour
package iolr_pkg;
  localparam int unsigned WIDTH       = 8;
  localparam logic [7:0]  STORE_RESET = 8'h00;
  localparam logic        VARIANT_LATCH    = 1'h0;
  localparam logic        VARIANT_REGISTER = 1'h1;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : iolr_pkg

// File: logic/iolr_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module iolr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         clock_enable,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge clock) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (clock_enable) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : iolr_sync
`default_nettype wire

// File: logic/iolr_top.sv
// Purpose: Octal storage element with inverting three-state outputs
// Assumes: Pins sampled on the 125 MHz clock after two flip-flops
// Notes:   Variant chosen by the variant_select input
`timescale 1ns/1ps
`default_nettype none
// Function
// - Eight bits share one gate or strobe and one output enable.
// - Latch variant passes all eight inputs while gate control is high.
// - Latch variant holds word when gate falls, ignoring inputs while low.
// - Register variant samples only on strobe rising edge, otherwise holds.
// - Each output bit is the complement of its stored bit.
// - Active-low enable drives outputs; high puts them in high impedance.
module iolr_top (
  // Clocking
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clock_enable,
  // Variant choice, same clock
  input  wire logic       variant_select,
  // Pin inputs
  input  wire logic [7:0] data_in,
  input  wire logic       capture_strobe,
  input  wire logic       output_enable_n,
  // Bus side
  output var  logic [7:0] data_out,
  output var  logic [7:0] data_out_en
);

  // Complement of a word
  function automatic logic [7:0] f_invert(
    input logic [7:0] word
  );
    logic [7:0] result;
    result = ~word;
    return result;
  endfunction : f_invert

  // Rising edge between two samples
  function automatic logic f_rising(
    input logic level,
    input logic prev
  );
    logic result;
    result = level & ~prev;
    return result;
  endfunction : f_rising

  // Falling edge between two samples
  function automatic logic f_falling(
    input logic level,
    input logic prev
  );
    logic result;
    result = ~level & prev;
    return result;
  endfunction : f_falling

  // Both conditions true
  function automatic logic f_both(
    input logic first,
    input logic second
  );
    logic result;
    result = first & second;
    return result;
  endfunction : f_both

  // Either condition true
  function automatic logic f_either(
    input logic first,
    input logic second
  );
    logic result;
    result = first | second;
    return result;
  endfunction : f_either

  // Fresh or held word
  function automatic logic [7:0] f_pick(
    input logic       take,
    input logic [7:0] fresh,
    input logic [7:0] held
  );
    logic [7:0] result;
    result = take ? fresh : held;
    return result;
  endfunction : f_pick

  // Variant code match
  function automatic logic f_is_variant(
    input logic select,
    input logic code
  );
    logic result;
    result = (select == code);
    return result;
  endfunction : f_is_variant

  // One enable spread over all lanes
  function automatic logic [7:0] f_spread(
    input logic enable
  );
    logic [7:0] result;
    result = {8{enable}};
    return result;
  endfunction : f_spread

  // Synchronised pins
  logic [7:0] data_sync;
  logic [1:0] control_sync;
  logic       strobe_sync;
  logic       oe_n_sync;

  // Edge tracking
  logic       strobe_prev;
  logic       next_strobe_prev;
  logic       strobe_rise;
  logic       strobe_fall;

  // Variant decode
  logic       is_latch;
  logic       is_register;

  // Load decision
  logic       gate_open;
  logic       load_latch;
  logic       load_register;
  logic       load_now;

  // Storage and output words
  logic [7:0] stored;
  logic [7:0] next_stored;
  logic [7:0] next_data_out;
  logic [7:0] reset_data_out;
  logic       drive_enable;

  // Data pins through two flip-flops
  iolr_sync #(
    .W (iolr_pkg::WIDTH)
  ) u_data_sync (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .async_in     (data_in),
    .sync_out     (data_sync)
  );

  // Strobe and enable pins through two flip-flops
  iolr_sync #(
    .W (2)
  ) u_control_sync (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .async_in     ({capture_strobe, output_enable_n}),
    .sync_out     (control_sync)
  );

  assign strobe_sync = control_sync[1];
  assign oe_n_sync   = control_sync[0];

  // Edge detection on the synchronised strobe
  assign strobe_rise      = f_rising(strobe_sync, strobe_prev);
  assign strobe_fall      = f_falling(strobe_sync, strobe_prev);
  assign next_strobe_prev = strobe_sync;

  // Variant decode
  assign is_latch    = f_is_variant(variant_select, iolr_pkg::VARIANT_LATCH);
  assign is_register = f_is_variant(variant_select, iolr_pkg::VARIANT_REGISTER);

  // Load decision, common to all eight lanes
  assign gate_open     = f_both(strobe_sync, ~strobe_fall);
  assign load_latch    = f_both(is_latch, gate_open);
  assign load_register = f_both(is_register, strobe_rise);
  assign load_now      = f_either(load_latch, load_register);

  // Enable plays no part in loading
  assign next_stored    = f_pick(load_now, data_sync, stored);
  assign next_data_out  = f_invert(next_stored);
  assign reset_data_out = f_invert(iolr_pkg::STORE_RESET);

  // Storage flip-flops, one per lane
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int lane = 0; lane < iolr_pkg::WIDTH; lane++) begin
        stored[lane] <= iolr_pkg::STORE_RESET[lane];
      end
    end else if (clock_enable) begin
      for (int lane = 0; lane < iolr_pkg::WIDTH; lane++) begin
        stored[lane] <= next_stored[lane];
      end
    end
  end

  // Edge tracker flip-flop
  always_ff @(posedge clock) begin
    if (reset) begin
      strobe_prev <= 1'b0;
    end else if (clock_enable) begin
      strobe_prev <= next_strobe_prev;
    end
  end

  // Output word flip-flops, one per lane
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int lane = 0; lane < iolr_pkg::WIDTH; lane++) begin
        data_out[lane] <= reset_data_out[lane];
      end
    end else if (clock_enable) begin
      for (int lane = 0; lane < iolr_pkg::WIDTH; lane++) begin
        data_out[lane] <= next_data_out[lane];
      end
    end
  end

  // Shared enable for all eight drivers
  assign drive_enable = ~oe_n_sync;
  assign data_out_en  = f_spread(drive_enable);
endmodule : iolr_top
`default_nettype wire

// File: test/iolr_assertions.sv
// Purpose: Concurrent checks on the octal latch/register ports
// Assumes: Pins reach the core through two flip-flops
// Notes:   Checks other than a_en_shared wait for four enabled cycles after reset or freeze
`timescale 1ns/1ps
`default_nettype none
module iolr_assertions (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       clock_enable,
  input wire logic       variant_select,
  input wire logic [7:0] data_in,
  input wire logic       capture_strobe,
  input wire logic       output_enable_n,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_out_en
);
  logic [2:0] settle;

  // Enabled cycles since reset or freeze, saturating
  always_ff @(posedge clock) begin
    if (reset || !clock_enable) begin
      settle <= 3'h0;
    end else if (settle != 3'h4) begin
      settle <= settle + 3'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset || !clock_enable);

  property p_en;
    settle == 3'h4 |-> data_out_en == {8{!$past(output_enable_n, 2)}};
  endproperty
  a_en: assert property (p_en) else $error("output enable mismatch");

  property p_en_shared;
    data_out_en == 8'h00 || data_out_en == 8'hff;
  endproperty
  a_en_shared: assert property (p_en_shared) else $error("lanes disagree on enable");

  property p_hold;
    !capture_strobe [*4] ##0 settle == 3'h4 |=> $stable(data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved with gate low");

  property p_latch_pass;
    settle == 3'h4 && !$past(variant_select) && $past(capture_strobe, 3) |-> data_out == ~$past(data_in, 3);
  endproperty
  a_latch_pass: assert property (p_latch_pass) else $error("open latch did not pass data");

  property p_reg_capture;
    settle == 3'h4 && $past(variant_select) && $past(capture_strobe, 3) && !$past(capture_strobe, 4)
      |-> data_out == ~$past(data_in, 3);
  endproperty
  a_reg_capture: assert property (p_reg_capture) else $error("strobe edge missed data");

  property p_reg_keep;
    settle == 3'h4 && $past(variant_select) && !($past(capture_strobe, 3) && !$past(capture_strobe, 4))
      |-> $stable(data_out);
  endproperty
  a_reg_keep: assert property (p_reg_keep) else $error("register moved without edge");
endmodule : iolr_assertions
bind iolr_top iolr_assertions iolr_assertions_inst (
  .clock           (clock),
  .reset           (reset),
  .clock_enable    (clock_enable),
  .variant_select  (variant_select),
  .data_in         (data_in),
  .capture_strobe  (capture_strobe),
  .output_enable_n (output_enable_n),
  .data_out        (data_out),
  .data_out_en     (data_out_en)
);
`default_nettype wire

// File: test/iolr_bus_model.sv
// Purpose: Shared bus as seen by the far side
// Assumes: No keeper on the bus lines
// Notes:   A released bus shows the inverse of the last driven word
`timescale 1ns/1ps
`default_nettype none
module iolr_bus_model (
  input  wire logic       clock,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_out_en,
  output var  logic [7:0] bus_level
);
  logic [7:0] last;

  always_ff @(posedge clock) begin
    if (&data_out_en) begin
      last <= data_out;
    end
  end

  assign bus_level = &data_out_en ? data_out : ~last;
endmodule : iolr_bus_model
`default_nettype wire

// File: test/testbench.sv
// Purpose: Self-checking bench for the octal latch/register
// Assumes: LFSR stimulus; latch, then register, then latch again
// Notes:   Includes a clock-enable freeze and a mid-run reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock           = 1'b0;
  logic        reset           = 1'b1;
  logic        clock_enable    = 1'b1;
  logic        variant_select  = 1'b0;
  logic        capture_strobe  = 1'b0;
  logic        output_enable_n = 1'b0;
  logic [7:0]  data_in         = 8'h00;
  logic [7:0]  data_out;
  logic [7:0]  data_out_en;
  logic [7:0]  bus_level;
  logic [15:0] r               = 16'he900;
  int          model_word      = 0;
  int          expect_q[$];
  int          mismatches      = 0;
  int          compares        = 0;

  always #4 clock = ~clock;

  iolr_top iolr_top_inst (
    .clock           (clock),
    .reset           (reset),
    .clock_enable    (clock_enable),
    .variant_select  (variant_select),
    .data_in         (data_in),
    .capture_strobe  (capture_strobe),
    .output_enable_n (output_enable_n),
    .data_out        (data_out),
    .data_out_en     (data_out_en)
  );

  iolr_bus_model iolr_bus_model_inst (
    .clock       (clock),
    .data_out    (data_out),
    .data_out_en (data_out_en),
    .bus_level   (bus_level)
  );

  function automatic logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], ^(x & 16'hb400)};
  endfunction : lf

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] expected);
    compares++;
    if (seen !== expected) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, expected, seen);
    end
  endtask : chk

  task automatic look;
    int word;
    repeat (4) @(posedge clock);
    #1;
    word = expect_q.pop_front();
    chk("drive word", {output_enable_n ? data_out : bus_level, data_out_en}, {~word[7:0], {8{~output_enable_n}}});
  endtask : look

  task automatic normal_step(input int i);
    logic strobe;
    logic variant;
    strobe  = r[8] && i != 59;
    variant = i > 49 && i < 90;
    if (variant ? strobe && !capture_strobe : strobe) begin
      model_word = int'(r[7:0]);
    end
    expect_q.push_back(model_word);
    variant_select  <= variant;
    output_enable_n <= &r[10:9];
    capture_strobe  <= strobe;
    data_in         <= r[7:0];
    look();
  endtask : normal_step

  task automatic freeze_step;
    expect_q.push_back(model_word);
    clock_enable   <= 1'b0;
    capture_strobe <= 1'b1;
    data_in        <= r[7:0];
    look();
    @(posedge clock);
    clock_enable <= 1'b1;
    model_word = int'(r[7:0]);
    expect_q.push_back(model_word);
    look();
  endtask : freeze_step

  task automatic reset_step;
    reset           <= 1'b1;
    capture_strobe  <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk("reset word", {data_out, data_out_en}, {~iolr_pkg::STORE_RESET, 8'hff});
    model_word = int'(iolr_pkg::STORE_RESET);
  endtask : reset_step

  task automatic summarize;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 130; i++) begin
      @(posedge clock);
      r = lf(r);
      if (i == 60) begin
        freeze_step();
      end else if (i == 90) begin
        reset_step();
      end else begin
        normal_step(i);
      end
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
